// file: hdl/rtxfm_pkg.sv
// Shared constants of the transmit buffer manager: map, fields, timing.
// Assumes a 100 MHz device clock and 16 us radio symbols.
package rtxfm_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Buffer map
  localparam int BUF_BYTES = 128;
  localparam logic [9:0] BUF_NORMAL_BASE = 10'h000;
  localparam logic [9:0] BUF_BEACON_BASE = 10'h080;
  localparam logic [9:0] BUF_SLOT1_BASE = 10'h100;
  localparam logic [9:0] BUF_SLOT2_BASE = 10'h180;
  localparam logic [1:0] BUF_NORMAL = 2'h0;
  localparam logic [1:0] BUF_BEACON = 2'h1;
  localparam logic [1:0] BUF_SLOT1 = 2'h2;
  localparam logic [1:0] BUF_SLOT2 = 2'h3;
  localparam logic [6:0] OFS_HDR_LEN = 7'h00;
  localparam logic [6:0] OFS_FRM_LEN = 7'h01;
  localparam logic [6:0] OFS_HEADER = 7'h02;
  localparam int HDR_LEN_BITS = 5;
  ////////////////////////////////////////////////////////////////////////
  // Registers and fields
  localparam logic [5:0] REG_BEACON_TX_CONTROL = 6'h1A;
  localparam logic [5:0] REG_NORMAL_TX_CONTROL = 6'h1B;
  localparam logic [5:0] REG_SLOT1_TX_CONTROL = 6'h1C;
  localparam logic [5:0] REG_SLOT2_TX_CONTROL = 6'h1D;
  localparam logic [5:0] REG_TX_RESULT_STATUS = 6'h24;
  localparam logic [5:0] REG_INTERRUPT_STATUS = 6'h31;
  localparam int BIT_SEND_TRIGGER = 0;
  localparam int BIT_SECURE_ENABLE = 1;
  localparam int BIT_ACK_REQUEST = 2;
  localparam int SLOT_LSB = 3;
  localparam int RETRY_LSB = 6;
  localparam int BIT_CHANNEL_BUSY_FAIL = 5;
  localparam int BIT_NORMAL_DONE = 0;
  localparam int BIT_SLOT1_DONE = 1;
  localparam int BIT_SLOT2_DONE = 2;
  ////////////////////////////////////////////////////////////////////////
  // Air framing
  localparam int PREAMBLE_BYTES = 4;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0] SFD_BYTE = 8'hA7;
  localparam logic [7:0] ACK_FCF_LO = 8'h02;
  localparam logic [7:0] ACK_FCF_HI = 8'h00;
  localparam logic [7:0] ACK_PHR = 8'h05;
  localparam logic [15:0] FCS_POLY = 16'h8408;
  localparam int FCS_BYTES = 2;
  localparam int MIC_LEN_DEF = 4;
  localparam int MAX_RETRY = 3;
  localparam int MAX_BACKOFF = 4;
  localparam int CAP_SLOTS_DEF = 8;
  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 10;
  localparam int SYMBOL_NS = 16000;
  localparam int ACK_WAIT_SYM = 54;
  localparam int IFS_SYM = 12;
  localparam int BACKOFF_SYM = 20;
  localparam int SLOT_SYM = 60;
  localparam int ACK_WAIT_CYC_DEF = ACK_WAIT_SYM * SYMBOL_NS / CLK_NS;
  localparam int IFS_CYC_DEF = (IFS_SYM * SYMBOL_NS + CLK_NS - 1) / CLK_NS;
  localparam int BACKOFF_CYC_DEF = (BACKOFF_SYM * SYMBOL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOT_CYC_DEF = SLOT_SYM * SYMBOL_NS / CLK_NS;
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CSMA = 4'h1,
    ST_SHR = 4'h3,
    ST_PHR = 4'h2,
    ST_BODY = 4'h6,
    ST_MIC = 4'h7,
    ST_FCS = 4'h5,
    ST_ACKW = 4'h4,
    ST_IFS = 4'hC
  } rtxfm_state_e;
endpackage

// file: hdl/rtxfm_if.sv
// Byte port between the host controller and the transmit manager.
// Both ends share one clock; reads answer in the following cycle.
`timescale 1ns/10ps
interface rtxfm_if;
  logic [9:0] addr;
  logic reg_sel;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [3:0] busy;
  modport dev (input addr, input reg_sel, input wdata, input wr, input rd,
    output rdata, output busy);
  modport host (output addr, output reg_sel, output wdata, output wr, output rd,
    input rdata, input busy);
endinterface

// file: hdl/rtxfm_device.sv
// Transmit buffer manager: four frame buffers, registers, send engine.
// Assumes host on rtxfm_if and a byte-pulling baseband on tx_*.
//
// Contract
// - Four 128-byte buffers, one frame each
// - Buffers mapped normal, beacon, slot1, slot2
// - Normal buffer: contention phase or nonbeacon
// - Slot buffers send in contention-free period
// - Layout: header length, frame length, header, payload
// - Header length five bits, secured frames only
// - Host writes frame length without FCS
// - Triggered send uses CSMA, ack wait, retries
// - Prepend sync and PHY header, append FCS
// - Secured frames get integrity code appended
// - Device keeps superframe timing and scheduling
// - Acknowledgments built in hardware, no buffer
// - Host sets normal_ack_request for acked frames
// - Host sets normal_secure_enable for encryption
// - normal_send_trigger starts, self clears
// - Done flag and normal_result on completion
// - Report retries used in normal_retry_count
// - channel_busy_fail on CSMA timeout
// - Host sets beacon_secure_enable for encryption
// - beacon_send_trigger starts, self clears
// - Beacon at superframe start, else immediately
// - Slot triggers self clear, send at slot
`timescale 1ns/10ps
module rtxfm_device import rtxfm_pkg::*; #(
  parameter int ACK_WAIT_CYC = ACK_WAIT_CYC_DEF,
  parameter int IFS_CYC = IFS_CYC_DEF,
  parameter int BACKOFF_CYC = BACKOFF_CYC_DEF,
  parameter int SLOT_CYC = SLOT_CYC_DEF,
  parameter int CAP_SLOTS = CAP_SLOTS_DEF,
  parameter int MIC_LEN = MIC_LEN_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  rtxfm_if.dev link,
  input wire logic beacon_mode_i,
  input wire logic channel_clear_i,
  input wire logic ack_rx_i,
  input wire logic ack_send_i,
  input wire logic [7:0] ack_seq_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o
);
  if (MIC_LEN < 1 || MIC_LEN > 16 || CAP_SLOTS < 1 || CAP_SLOTS > 8 ||
      ACK_WAIT_CYC < 1 || IFS_CYC < 1 || BACKOFF_CYC < 1 || SLOT_CYC < 1 ||
      ACK_WAIT_CYC >= 2**24 || SLOT_CYC >= 2**24) begin : g_bad_param
    $error("rtxfm_device: parameter out of range");
  end

  typedef struct packed {
    logic [7:0] rdata;
    logic [1:0] bctl;
    logic [2:0] nctl;
    logic [7:0] g1ctl;
    logic [7:0] g2ctl;
    logic [7:0] tx_result_status;
    logic [2:0] ints;
    rtxfm_state_e st;
    logic [1:0] src;
    logic is_ack;
    logic sec;
    logic ackreq;
    logic ok;
    logic cca;
    logic [6:0] idx;
    logic [6:0] flen;
    logic [4:0] hlen;
    logic [23:0] cnt;
    logic [2:0] nb;
    logic [1:0] retry;
    logic [15:0] crc;
    logic [7:0] mic;
    logic ack_pend;
    logic [7:0] ack_seq;
    logic [23:0] slot_cnt;
    logic [3:0] slot_idx;
    logic txv;
    logic [7:0] txd;
  } rtxfm_dev_s;

  rtxfm_dev_s s;
  rtxfm_dev_s n;
  logic [7:0] mem [0:4*BUF_BYTES-1];
  logic [7:0] reg_rd;
  logic [7:0] eb;
  logic adv;
  logic sf_start;
  logic in_cap;
  logic [3:0] g1_slot;
  logic [3:0] g2_slot;
  logic take;
  logic [1:0] take_src;
  logic last;

  function automatic logic [15:0] fcs_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ d[i];
      r = r >> 1;
      if (fb) begin
        r = r ^ FCS_POLY;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Buffer memory and register read mux
  always_ff @(posedge sys_clk_i) begin
    if (link.wr && !link.reg_sel) begin
      mem[link.addr[8:0]] <= link.wdata;
    end
  end

  assign reg_rd = (link.addr[5:0] == REG_BEACON_TX_CONTROL) ? {6'h00, s.bctl} :
                  (link.addr[5:0] == REG_NORMAL_TX_CONTROL) ? {5'h00, s.nctl} :
                  (link.addr[5:0] == REG_SLOT1_TX_CONTROL) ? s.g1ctl :
                  (link.addr[5:0] == REG_SLOT2_TX_CONTROL) ? s.g2ctl :
                  (link.addr[5:0] == REG_TX_RESULT_STATUS) ? s.tx_result_status :
                  (link.addr[5:0] == REG_INTERRUPT_STATUS) ? {5'h00, s.ints} : 8'h00;
  assign link.busy = {s.g2ctl[0], s.g1ctl[0], s.bctl[0], s.nctl[0]} |
                     ((s.st != ST_IDLE && !s.is_ack) ? (4'h1 << s.src) : 4'h0);
  assign tx_valid_o = s.txv;
  assign tx_data_o = s.txd;
  assign link.rdata = s.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Superframe and scheduling terms
  assign sf_start = beacon_mode_i && s.slot_idx == 4'h0 && s.slot_cnt == 24'h000000;
  assign in_cap = s.slot_idx < 4'(CAP_SLOTS);
  assign g1_slot = 4'(CAP_SLOTS) + {1'b0, s.g1ctl[5:3]};
  assign g2_slot = 4'(CAP_SLOTS) + {1'b0, s.g2ctl[5:3]};
  assign adv = !s.txv || tx_ready_i;
  assign take = s.st == ST_IDLE && !s.ack_pend &&
                ((s.bctl[0] && (!beacon_mode_i || sf_start)) ||
                 (beacon_mode_i && s.g1ctl[0] && s.slot_idx == g1_slot) ||
                 (beacon_mode_i && s.g2ctl[0] && s.slot_idx == g2_slot) ||
                 (s.nctl[0] && (!beacon_mode_i || in_cap)));
  assign take_src = (s.bctl[0] && (!beacon_mode_i || sf_start)) ? BUF_BEACON :
                    (beacon_mode_i && s.g1ctl[0] && s.slot_idx == g1_slot) ? BUF_SLOT1 :
                    (beacon_mode_i && s.g2ctl[0] && s.slot_idx == g2_slot) ? BUF_SLOT2 :
                    BUF_NORMAL;
  assign last = s.idx == (s.is_ack ? 7'h02 : 7'(s.flen - 7'h01));

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = s;
    eb = 8'h00;
    if (link.rd) begin
      n.rdata = link.reg_sel ? reg_rd : mem[link.addr[8:0]];
      if (link.reg_sel && link.addr[5:0] == REG_INTERRUPT_STATUS) begin
        n.ints = 3'h0;
      end
    end
    if (!beacon_mode_i) begin
      n.slot_cnt = 24'h000000;
      n.slot_idx = 4'h0;
    end else if (s.slot_cnt == 24'(SLOT_CYC - 1)) begin
      n.slot_cnt = 24'h000000;
      n.slot_idx = s.slot_idx + 4'h1;
    end else begin
      n.slot_cnt = s.slot_cnt + 24'h000001;
    end
    if (tx_ready_i) begin
      n.txv = 1'b0;
    end
    case (s.st)
      ST_IDLE: begin
        n.idx = 7'h00;
        n.cnt = 24'h000000;
        n.nb = 3'h0;
        n.retry = 2'h0;
        n.ok = 1'b0;
        n.cca = 1'b0;
        if (s.ack_pend) begin
          n.ack_pend = 1'b0;
          n.is_ack = 1'b1;
          n.sec = 1'b0;
          n.st = ST_SHR;
        end else if (take) begin
          n.is_ack = 1'b0;
          n.src = take_src;
          n.hlen = mem[{take_src, OFS_HDR_LEN}][HDR_LEN_BITS-1:0];
          n.flen = mem[{take_src, OFS_FRM_LEN}][6:0];
          n.st = (take_src == BUF_NORMAL) ? ST_CSMA : ST_SHR;
          case (take_src)
            BUF_BEACON: begin
              n.bctl[BIT_SEND_TRIGGER] = 1'b0;
              n.sec = s.bctl[BIT_SECURE_ENABLE];
              n.ackreq = 1'b0;
            end
            BUF_SLOT1: begin
              n.g1ctl[BIT_SEND_TRIGGER] = 1'b0;
              n.sec = s.g1ctl[BIT_SECURE_ENABLE];
              n.ackreq = s.g1ctl[BIT_ACK_REQUEST];
            end
            BUF_SLOT2: begin
              n.g2ctl[BIT_SEND_TRIGGER] = 1'b0;
              n.sec = s.g2ctl[BIT_SECURE_ENABLE];
              n.ackreq = s.g2ctl[BIT_ACK_REQUEST];
            end
            default: begin
              n.nctl[BIT_SEND_TRIGGER] = 1'b0;
              n.sec = s.nctl[BIT_SECURE_ENABLE];
              n.ackreq = s.nctl[BIT_ACK_REQUEST];
            end
          endcase
        end
      end
      ST_CSMA: begin
        n.cnt = s.cnt + 24'h000001;
        if (s.cnt == 24'(BACKOFF_CYC - 1)) begin
          n.cnt = 24'h000000;
          if (channel_clear_i) begin
            n.st = ST_SHR;
          end else if (s.nb == 3'(MAX_BACKOFF - 1)) begin
            n.cca = 1'b1;
            n.st = ST_IFS;
          end else begin
            n.nb = s.nb + 3'h1;
          end
        end
      end
      ST_SHR: begin
        if (adv) begin
          eb = (s.idx < 7'(PREAMBLE_BYTES)) ? PREAMBLE_BYTE : SFD_BYTE;
          n.idx = s.idx + 7'h01;
          if (s.idx == 7'(PREAMBLE_BYTES)) begin
            n.idx = 7'h00;
            n.st = ST_PHR;
          end
        end
      end
      ST_PHR: begin
        if (adv) begin
          eb = s.is_ack ? ACK_PHR :
               8'(s.flen + 7'(FCS_BYTES) + (s.sec ? 7'(MIC_LEN) : 7'h00));
          n.crc = 16'h0000;
          n.mic = 8'h00;
          n.st = ST_BODY;
        end
      end
      ST_BODY: begin
        if (adv) begin
          eb = !s.is_ack ? mem[{s.src, 7'(s.idx + OFS_HEADER)}] :
               (s.idx == 7'h00) ? ACK_FCF_LO :
               (s.idx == 7'h01) ? ACK_FCF_HI : s.ack_seq;
          n.crc = fcs_step(s.crc, eb);
          if (s.sec && s.idx >= {2'h0, s.hlen}) begin
            n.mic = s.mic ^ eb;
          end
          n.idx = s.idx + 7'h01;
          if (last) begin
            n.idx = 7'h00;
            n.st = s.sec ? ST_MIC : ST_FCS;
          end
        end
      end
      ST_MIC: begin
        if (adv) begin
          eb = s.mic;
          n.crc = fcs_step(s.crc, eb);
          n.idx = s.idx + 7'h01;
          if (s.idx == 7'(MIC_LEN - 1)) begin
            n.idx = 7'h00;
            n.st = ST_FCS;
          end
        end
      end
      ST_FCS: begin
        if (adv) begin
          eb = (s.idx == 7'h00) ? s.crc[7:0] : s.crc[15:8];
          n.idx = s.idx + 7'h01;
          if (s.idx == 7'(FCS_BYTES - 1)) begin
            n.idx = 7'h00;
            n.cnt = 24'h000000;
            n.ok = !s.ackreq;
            n.st = s.is_ack ? ST_IDLE : (s.ackreq ? ST_ACKW : ST_IFS);
          end
        end
      end
      ST_ACKW: begin
        n.cnt = s.cnt + 24'h000001;
        if (ack_rx_i) begin
          n.ok = 1'b1;
          n.cnt = 24'h000000;
          n.st = ST_IFS;
        end else if (s.cnt == 24'(ACK_WAIT_CYC - 1)) begin
          n.cnt = 24'h000000;
          if (s.retry == 2'(MAX_RETRY)) begin
            n.st = ST_IFS;
          end else begin
            n.retry = s.retry + 2'h1;
            n.nb = 3'h0;
            n.st = (s.src == BUF_NORMAL) ? ST_CSMA : ST_SHR;
          end
        end
      end
      ST_IFS: begin
        n.cnt = s.txv ? 24'h000000 : s.cnt + 24'h000001;
        if (!s.txv && s.cnt == 24'(IFS_CYC - 1)) begin
          n.st = ST_IDLE;
          case (s.src)
            BUF_NORMAL: begin
              n.ints[BIT_NORMAL_DONE] = 1'b1;
              n.tx_result_status[0] = s.ok;
              n.tx_result_status[RETRY_LSB +: 2] = s.retry;
              n.tx_result_status[BIT_CHANNEL_BUSY_FAIL] = s.cca;
            end
            BUF_SLOT1: begin
              n.ints[BIT_SLOT1_DONE] = 1'b1;
              n.tx_result_status[1] = s.ok;
              n.g1ctl[RETRY_LSB +: 2] = s.retry;
            end
            BUF_SLOT2: begin
              n.ints[BIT_SLOT2_DONE] = 1'b1;
              n.tx_result_status[2] = s.ok;
              n.g2ctl[RETRY_LSB +: 2] = s.retry;
            end
            default: ;
          endcase
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (s.st inside {ST_SHR, ST_PHR, ST_BODY, ST_MIC, ST_FCS} && adv) begin
      n.txv = 1'b1;
      n.txd = eb;
    end
    if (ack_send_i) begin
      n.ack_pend = 1'b1;
      n.ack_seq = ack_seq_i;
    end
    if (link.wr && link.reg_sel) begin
      case (link.addr[5:0])
        REG_BEACON_TX_CONTROL: n.bctl = link.wdata[1:0];
        REG_NORMAL_TX_CONTROL: n.nctl = link.wdata[2:0];
        REG_SLOT1_TX_CONTROL: n.g1ctl[5:0] = link.wdata[5:0];
        REG_SLOT2_TX_CONTROL: n.g2ctl[5:0] = link.wdata[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

// file: hdl/rtxfm_host.sv
// Host end: turns command-port orders into buffer and register accesses.
// Assumes the device on rtxfm_if answers reads in the next cycle.
`timescale 1ns/10ps
module rtxfm_host import rtxfm_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  output logic [7:0] cmd_rdata_o,
  rtxfm_if.host link
);
  localparam logic [2:0] CMD_ADDR_LO = 3'h0;
  localparam logic [2:0] CMD_ADDR_HI = 3'h1;
  localparam logic [2:0] CMD_DATA = 3'h2;
  localparam logic [2:0] CMD_READ = 3'h3;
  localparam logic [2:0] CMD_STATUS = 3'h4;

  typedef struct packed {
    logic [9:0] addr;
    logic rsel;
    logic lwr;
    logic lrd;
    logic [7:0] lwd;
    logic [9:0] laddr;
    logic lsel;
    logic rd_pend;
    logic rdv;
    logic [7:0] rbuf;
    logic refused;
    logic [7:0] rdata;
  } rtxfm_host_s;

  rtxfm_host_s s;
  rtxfm_host_s n;
  logic blocked;

  assign blocked = !s.rsel && link.busy[s.addr[8:7]];
  assign link.addr = s.laddr;
  assign link.reg_sel = s.lsel;
  assign link.wdata = s.lwd;
  assign link.wr = s.lwr;
  assign link.rd = s.lrd;
  assign cmd_rdata_o = s.rdata;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    n.lwr = 1'b0;
    n.lrd = 1'b0;
    n.rd_pend = s.lrd;
    if (s.rd_pend) begin
      n.rbuf = link.rdata;
      n.rdv = 1'b1;
    end
    if (cmd_rd_i) begin
      case (cmd_addr_i)
        CMD_ADDR_LO: n.rdata = s.addr[7:0];
        CMD_ADDR_HI: n.rdata = {s.rsel, 5'h00, s.addr[9:8]};
        CMD_DATA: n.rdata = s.rbuf;
        CMD_STATUS: n.rdata = {link.busy, 2'h0, s.rdv, s.refused};
        default: n.rdata = 8'h00;
      endcase
    end
    if (cmd_wr_i) begin
      case (cmd_addr_i)
        CMD_ADDR_LO: n.addr[7:0] = cmd_wdata_i;
        CMD_ADDR_HI: begin
          n.addr[9:8] = cmd_wdata_i[1:0];
          n.rsel = cmd_wdata_i[7];
        end
        CMD_DATA: begin
          if (blocked) begin
            n.refused = 1'b1;
          end else begin
            n.lwr = 1'b1;
            n.lwd = cmd_wdata_i;
            n.laddr = s.addr;
            n.lsel = s.rsel;
            if (!s.rsel) begin
              n.addr = s.addr + 10'h001;
            end
          end
        end
        CMD_READ: begin
          n.lrd = 1'b1;
          n.rdv = 1'b0;
          n.laddr = s.addr;
          n.lsel = s.rsel;
          if (!s.rsel) begin
            n.addr = s.addr + 10'h001;
          end
        end
        CMD_STATUS: begin
          if (cmd_wdata_i[0]) begin
            n.refused = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

// file: tb/rtxfm_props.sv
// Concurrent checks on the host-device byte port and the air output.
// Assumes a receiver-side ack request only comes while no frame is on air.
`timescale 1ns/10ps
module rtxfm_props import rtxfm_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] addr,
  input wire logic reg_sel,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic [3:0] busy,
  input wire logic beacon_mode_i,
  input wire logic ack_send_i,
  input wire logic tx_ready_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] ack_left;
  ////////////////////////////////////////////////////////////////////////
  // Bytes of a hardware ack frame still to leave
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ack_left <= 4'h0;
    end else if (ack_send_i) begin
      ack_left <= 4'(PREAMBLE_BYTES + 5 + FCS_BYTES);
    end else if (ack_left != 4'h0 && tx_valid_o && tx_ready_i) begin
      ack_left <= ack_left - 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  trig_norm_a: assert property (
    wr && reg_sel && addr[5:0] == REG_NORMAL_TX_CONTROL && wdata[0] |=> busy[0])
    else $error("normal trigger ignored");
  trig_bcn_a: assert property (
    wr && reg_sel && addr[5:0] == REG_BEACON_TX_CONTROL && wdata[0] |=> busy[1])
    else $error("beacon trigger ignored");
  trig_slot_a: assert property (
    wr && reg_sel && addr[5:0] == REG_SLOT1_TX_CONTROL && wdata[0] |=> busy[2])
    else $error("slot trigger ignored");
  busy_guard_a: assert property (
    wr && !reg_sel |-> !busy[addr[8:7]])
    else $error("pending buffer written");
  frame_start_a: assert property (
    $rose(tx_valid_o) |-> tx_data_o == PREAMBLE_BYTE)
    else $error("frame does not open with preamble");
  byte_hold_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("air byte changed before taken");
  beacon_now_a: assert property (
    $rose(busy[1]) && !beacon_mode_i && !busy[0] && !tx_valid_o |-> ##[1:12] tx_valid_o)
    else $error("beacon not sent at once");
  slot_hold_a: assert property (
    !beacon_mode_i && busy == 4'h4 |-> !tx_valid_o)
    else $error("slot frame sent without superframe");
  idle_quiet_a: assert property (
    busy == 4'h0 && ack_left == 4'h0 |-> !tx_valid_o)
    else $error("air activity with no buffer pending");
  ack_nobuf_a: assert property (
    ack_left != 4'h0 |-> busy == 4'h0)
    else $error("ack frame marked a buffer busy");
endmodule

// file: tb/rtxfm_test.sv
// Bench: host end and device end joined on one byte port.
// Assumes short timing parameters; one receiver-side ack is requested while idle.
`timescale 1ns/10ps
module rtxfm_test import rtxfm_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] c_addr = 3'h0;
  logic [7:0] c_wdata = 8'h00;
  logic c_wr = 1'b0;
  logic c_rd = 1'b0;
  logic [7:0] c_rdata;
  logic beacon_mode = 1'b0;
  logic chan_clear = 1'b1;
  logic ack_rx = 1'b0;
  logic ack_send = 1'b0;
  logic [7:0] ack_seq = 8'h00;
  logic tx_ready = 1'b0;
  logic tx_valid;
  logic [7:0] tx_data;
  logic rd_d = 1'b0;
  logic [7:0] body[$];
  logic [7:0] air_q[$];
  logic [15:0] rd_q[$];
  logic [4:0] hlen;
  int n_mismatch = 0;
  int checks = 0;
  rtxfm_if bus();
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////
  rtxfm_host rtxfm_host_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cmd_addr_i(c_addr),
    .cmd_wdata_i(c_wdata), .cmd_wr_i(c_wr), .cmd_rd_i(c_rd), .cmd_rdata_o(c_rdata),
    .link(bus));
  rtxfm_device #(.ACK_WAIT_CYC(20), .IFS_CYC(4), .BACKOFF_CYC(5), .SLOT_CYC(50),
    .CAP_SLOTS(CAP_SLOTS_DEF), .MIC_LEN(MIC_LEN_DEF)) rtxfm_device_i (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(bus), .beacon_mode_i(beacon_mode),
    .channel_clear_i(chan_clear), .ack_rx_i(ack_rx), .ack_send_i(ack_send),
    .ack_seq_i(ack_seq), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data));
  rtxfm_props rtxfm_props_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .addr(bus.addr),
    .reg_sel(bus.reg_sel), .wdata(bus.wdata), .wr(bus.wr), .busy(bus.busy),
    .beacon_mode_i(beacon_mode), .ack_send_i(ack_send), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data));
  ////////////////////////////////////////////////////////////////////////
  task automatic note_err(input string what);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, what);
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [15:0] e);
    checks++;
    if ((got & e[15:8]) !== (e[7:0] & e[15:8])) note_err($sformatf("read %h", got));
  endtask
  task automatic cmp_air(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e) note_err($sformatf("air %h exp %h", got, e));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) tx_ready <= ($urandom % 4) != 0;
  always @(posedge sys_clk) begin
    rd_d <= c_rd;
    if (rd_d) begin
      if (rd_q.size() == 0) note_err("stray read");
      else cmp_rd(c_rdata, rd_q.pop_front());
    end
    if (rst_n && tx_valid && tx_ready) begin
      if (air_q.size() == 0) note_err("stray air byte");
      else cmp_air(tx_data, air_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    c_addr <= a;
    c_wdata <= d;
    c_wr <= 1'b1;
    @(posedge sys_clk);
    c_wr <= 1'b0;
  endtask
  task automatic host_rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge sys_clk);
    c_addr <= a;
    c_rd <= 1'b1;
    rd_q.push_back({m, e});
    @(posedge sys_clk);
    c_rd <= 1'b0;
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    host_wr(3'h0, {2'b00, a});
    host_wr(3'h1, 8'h80);
    host_wr(3'h2, d);
  endtask
  task automatic reg_rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    host_wr(3'h0, {2'b00, a});
    host_wr(3'h1, 8'h80);
    host_wr(3'h3, 8'h00);
    repeat (3) @(posedge sys_clk);
    host_rd(3'h2, e, m);
  endtask
  task automatic load(input logic [9:0] base, input logic [7:0] mb, input int n);
    body.delete();
    hlen = mb[4:0];
    host_wr(3'h0, base[7:0]);
    host_wr(3'h1, {6'h00, base[9:8]});
    host_wr(3'h2, mb);
    host_wr(3'h2, 8'(n));
    repeat (n) begin
      body.push_back(8'($urandom));
      host_wr(3'h2, body[$]);
    end
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ FCS_POLY) : (c >> 1);
    return c;
  endfunction
  task automatic push_air(input logic sec);
    logic [15:0] c;
    logic [7:0] x;
    c = 16'h0000;
    x = 8'h00;
    repeat (PREAMBLE_BYTES) air_q.push_back(PREAMBLE_BYTE);
    air_q.push_back(SFD_BYTE);
    air_q.push_back(8'(body.size() + FCS_BYTES + (sec ? MIC_LEN_DEF : 0)));
    foreach (body[i]) begin
      air_q.push_back(body[i]);
      c = crc_step(c, body[i]);
      if (i >= hlen) x = x ^ body[i];
    end
    if (sec) repeat (MIC_LEN_DEF) begin
      air_q.push_back(x);
      c = crc_step(c, x);
    end
    air_q.push_back(c[7:0]);
    air_q.push_back(c[15:8]);
  endtask
  task automatic settle(input logic idle);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while ((air_q.size() != 0 || tx_valid || (idle && bus.busy != 4'h0)) && k < 3000);
    if (k >= 3000) note_err("wait limit reached");
  endtask
  task automatic run_normal(input logic [7:0] ctl, input int n, input logic ack,
    input logic [7:0] e24);
    reg_wr(REG_NORMAL_TX_CONTROL, ctl);
    repeat (n) begin
      push_air(ctl[1]);
      settle(1'b0);
    end
    if (ack) begin
      @(posedge sys_clk);
      ack_rx <= 1'b1;
      @(posedge sys_clk);
      ack_rx <= 1'b0;
    end
    settle(1'b1);
    reg_rd(REG_TX_RESULT_STATUS, e24, 8'hE1);
  endtask
  task automatic send_ack();
    @(posedge sys_clk);
    ack_seq <= 8'($urandom);
    ack_send <= 1'b1;
    @(posedge sys_clk);
    ack_send <= 1'b0;
    body.delete();
    body.push_back(ACK_FCF_LO);
    body.push_back(ACK_FCF_HI);
    body.push_back(ack_seq);
    push_air(1'b0);
    settle(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    note_err("watchdog expired");
    stop_test();
  end
  initial begin
    void'($urandom(85));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_rd(REG_TX_RESULT_STATUS, 8'h00, 8'hFF);
    reg_rd(REG_INTERRUPT_STATUS, 8'h00, 8'hFF);
    reg_rd(6'h3F, 8'h00, 8'hFF);
    host_rd(3'h4, 8'h00, 8'hF1);
    load(BUF_NORMAL_BASE, 8'h03, 5);
    run_normal(8'h01, 1, 1'b0, 8'h01);
    reg_rd(REG_INTERRUPT_STATUS, 8'h01, 8'h07);
    send_ack();
    reg_rd(REG_INTERRUPT_STATUS, 8'h00, 8'h07);
    reg_rd(REG_NORMAL_TX_CONTROL, 8'h00, 8'h01);
    load(BUF_NORMAL_BASE, 8'hE2, 6);
    run_normal(8'h03, 1, 1'b0, 8'h01);
    run_normal(8'h05, 2, 1'b1, 8'h41);
    run_normal(8'h05, MAX_RETRY + 1, 1'b0, 8'hC0);
    chan_clear <= 1'b0;
    reg_wr(REG_NORMAL_TX_CONTROL, 8'h01);
    load(BUF_NORMAL_BASE, 8'h02, 3);
    host_rd(3'h4, 8'h01, 8'h01);
    settle(1'b1);
    reg_rd(REG_TX_RESULT_STATUS, 8'h20, 8'hE1);
    host_wr(3'h4, 8'h01);
    host_rd(3'h4, 8'h00, 8'h01);
    load(BUF_BEACON_BASE, 8'h02, 4);
    reg_wr(REG_BEACON_TX_CONTROL, 8'h01);
    push_air(1'b0);
    settle(1'b1);
    reg_rd(REG_BEACON_TX_CONTROL, 8'h00, 8'h01);
    chan_clear <= 1'b1;
    load(BUF_SLOT1_BASE, 8'h02, 4);
    reg_wr(REG_SLOT1_TX_CONTROL, 8'h01);
    repeat (100) @(posedge sys_clk);
    host_rd(3'h4, 8'h40, 8'hF0);
    push_air(1'b0);
    beacon_mode <= 1'b1;
    settle(1'b1);
    reg_rd(REG_TX_RESULT_STATUS, 8'h02, 8'h02);
    reg_rd(REG_SLOT1_TX_CONTROL, 8'h00, 8'h01);
    load(BUF_BEACON_BASE, 8'h02, 3);
    reg_wr(REG_BEACON_TX_CONTROL, 8'h03);
    push_air(1'b1);
    settle(1'b1);
    stop_test();
  end
endmodule
